/* File: sync_fifo_flags.sv */
// sync_fifo_flags: 9-bit synchronous fifo with full, empty, almost flags and reset strap
// assumes write and read sides are sampled on mclk_i; offsets come from outside logic
`timescale 1ns/10ps

// Functional notes
// RQ1 - full flag releases in the same cycle as the read that frees a word
// RQ2 - empty flag releases in the same cycle as the write that adds a word
// RQ3 - clocks may run throughout reset; reset works without stopping them
// RQ4 - pin high through reset makes it a second active-high write enable
// RQ5 - pin low through reset makes it the offset register load enable
// RQ6 - after reset outputs are zero when enabled, undriven when disabled
// RQ7 - first word readable in the read cycle right after empty releases
// RQ8 - almost-empty flag changes in the current read cycle
// RQ9 - almost-empty asserts low when fewer than n words remain
// RQ10 - almost-full asserts low at depth minus m plus one words
// RQ11 - almost-full threshold is depth minus m; depth set by parameter
// RQ12 - almost-full flag changes in the current write cycle
// RQ13 - driver never gives pulses shorter than minimum widths
// RQ14 - store a word only with both write enables active and not full
// RQ15 - remove a word only with both read enables low and not empty
module sync_fifo_flags #(
	parameter int DEPTH = fifo_cfg_pkg::DEPTH_DEFAULT,
	parameter int AW    = $clog2(DEPTH),
	parameter int CW    = AW + 1
) (
	input  wire logic                            mclk_i,
	input  wire logic                            reset_n_i,
	input  wire logic                            write_enable_n_i,
	input  wire logic                            second_enable_or_load_i,
	input  wire logic [fifo_cfg_pkg::DATA_W-1:0] data_i,
	input  wire logic                            read_enable_a_n_i,
	input  wire logic                            read_enable_b_n_i,
	input  wire logic                            output_enable_n_i,
	input  wire logic                            out_ready_i,
	input  wire logic [CW-1:0]                   ae_offset_i,
	input  wire logic [CW-1:0]                   af_offset_i,
	output logic      [fifo_cfg_pkg::DATA_W-1:0] data_o,
	output logic                                 data_oe_o,
	output logic                                 out_valid_o,
	output logic                                 full_flag_n_o,
	output logic                                 empty_flag_n_o,
	output logic                                 almost_empty_flag_n_o,
	output logic                                 almost_full_flag_n_o,
	output logic                                 offset_load_o,
	output logic                                 second_we_mode_o
);
	import fifo_cfg_pkg::*;

	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
	localparam logic [CW-1:0] ONE_C   = CW'(1);

	logic                  rst_meta_q;
	logic                  rst_n;
	pin_mode_t             mode_q;
	logic [AW-1:0]         wr_ptr_q;
	logic [AW-1:0]         rd_ptr_q;
	logic [CW-1:0]         cnt_q;
	logic [CW-1:0]         cnt_d;
	logic                  full_n_q;
	logic                  empty_n_q;
	logic                  ae_n_q;
	logic                  af_n_q;
	logic                  rd_pend_q;
	logic [DATA_W-1:0]     mem_rdata;
	logic [DATA_W-1:0]     out_q;
	logic                  out_vld_q;
	logic [DATA_W-1:0]     spare_q;
	logic                  spare_vld_q;

	// true when the count sits at or above a threshold
	function automatic logic at_least(input logic [CW-1:0] cnt, input logic [CW-1:0] thr);
		at_least = (cnt >= thr);
	endfunction : at_least

	// reset released through two flops so every flop leaves reset on one edge
	// RQ3 clocks may run
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// strap: the pin is followed every cycle while reset is held, then frozen
	// RQ4 RQ5 strap capture
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n)
			mode_q <= pin_mode_t'(second_enable_or_load_i);
	end

	// request decode; the pin must be high to write in either mode
	wire write_req  = !write_enable_n_i && second_enable_or_load_i;
	wire read_req   = !read_enable_a_n_i && !read_enable_b_n_i;
	wire buf_pop    = out_vld_q && out_ready_i;
	wire [1:0] buf_used = 2'(out_vld_q) + 2'(spare_vld_q) + 2'(rd_pend_q) - 2'(buf_pop);
	wire buf_room   = buf_used < BUF_ENTRIES;
	// RQ14 write gate
	wire wr_go      = write_req && full_n_q;
	// RQ15 read gate; a full skid buffer stalls the read side
	wire rd_go      = read_req && empty_n_q && buf_room;

	// RQ5 load strobe
	assign offset_load_o    = rst_n && (mode_q == MODE_LOAD) && !write_enable_n_i
		&& !second_enable_or_load_i;
	assign second_we_mode_o = (mode_q == MODE_SECOND_WE);

	// occupancy next value
	always_comb
	begin
		cnt_d = cnt_q;
		if (wr_go && !rd_go)
			cnt_d = cnt_q + ONE_C;
		else if (rd_go && !wr_go)
			cnt_d = cnt_q - ONE_C;
	end

	// pointers, count and flags; flags are computed from the next count so they
	// move on the very edge that changes occupancy, well inside both skew windows
	always_ff @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_q  <= '0;
			rd_ptr_q  <= '0;
			cnt_q     <= '0;
			rd_pend_q <= 1'b0;
			full_n_q  <= FLAG_IDLE_N;
			empty_n_q <= FLAG_ACTIVE_N;
			ae_n_q    <= FLAG_ACTIVE_N;
			af_n_q    <= FLAG_IDLE_N;
		end
		else
		begin
			if (wr_go)
				wr_ptr_q <= wr_ptr_q + AW'(1);
			if (rd_go)
				rd_ptr_q <= rd_ptr_q + AW'(1);
			cnt_q     <= cnt_d;
			rd_pend_q <= rd_go;
			// RQ1 full release
			full_n_q  <= !(cnt_d == DEPTH_C);
			// RQ2 RQ7 empty release
			empty_n_q <= !(cnt_d == '0);
			// RQ8 RQ9 almost empty
			ae_n_q    <= at_least(cnt_d, ae_offset_i);
			// RQ10 RQ11 RQ12 almost full
			af_n_q    <= !at_least(cnt_d, DEPTH_C - af_offset_i + ONE_C);
		end
	end

	assign full_flag_n_o         = full_n_q;
	assign empty_flag_n_o        = empty_n_q;
	assign almost_empty_flag_n_o = ae_n_q;
	assign almost_full_flag_n_o  = af_n_q;

	fifo_store #(
		.WIDTH (DATA_W),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_store (
		.mclk_i    (mclk_i),
		.wr_en_i   (wr_go),
		.wr_addr_i (wr_ptr_q),
		.wr_data_i (data_i),
		.rd_en_i   (rd_go),
		.rd_addr_i (rd_ptr_q),
		.rd_data_o (mem_rdata)
	);

	// two-entry skid buffer: head drives the pins, spare catches a word when the
	// receiver stalls, so a read already issued never loses its data
	always_ff @(posedge mclk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_q       <= '0;
			out_vld_q   <= 1'b0;
			spare_q     <= '0;
			spare_vld_q <= 1'b0;
		end
		else if (!out_vld_q || buf_pop)
		begin
			if (spare_vld_q)
			begin
				out_q       <= spare_q;
				out_vld_q   <= 1'b1;
				spare_q     <= mem_rdata;
				spare_vld_q <= rd_pend_q;
			end
			else if (rd_pend_q)
			begin
				out_q     <= mem_rdata;
				out_vld_q <= 1'b1;
			end
			else
				out_vld_q <= 1'b0;
		end
		else if (rd_pend_q)
		begin
			spare_q     <= mem_rdata;
			spare_vld_q <= 1'b1;
		end
	end

	// RQ6 output drive; head keeps its last word, zero after reset
	assign data_o      = out_q;
	assign data_oe_o   = !output_enable_n_i;
	assign out_valid_o = out_vld_q;

	// RQ1 full release
	chk_full_release: assert property (@(posedge mclk_i) disable iff (!rst_n) // RQ1
		(rd_go && !wr_go && cnt_q == DEPTH_C) |=> full_flag_n_o)
		else $error("full flag did not release after read");

	// RQ2 empty release
	chk_empty_release: assert property (@(posedge mclk_i) disable iff (!rst_n) // RQ2
		(wr_go && cnt_q == '0) |=> ##(FLAG_CLOCK_SKEW_FIRST_CYC - 1) empty_flag_n_o)
		else $error("empty flag did not release after write");

	// RQ4 strap follows the pin
	chk_strap_capture: assert property (@(posedge mclk_i) disable iff (!rst_n) // RQ4
		$rose(rst_n) |-> (second_we_mode_o == $past(second_enable_or_load_i)))
		else $error("pin mode not taken from last reset level");

	// RQ5 load strobe never writes the fifo
	chk_load_no_write: assert property (@(posedge mclk_i) disable iff (!rst_n) // RQ5
		offset_load_o |=> $stable(wr_ptr_q))
		else $error("load cycle moved the write pointer");

	// RQ6 zero output after reset
	chk_reset_output: assert property (@(posedge mclk_i) disable iff (!rst_n) // RQ6
		$rose(rst_n) |-> (data_o == '0 && data_oe_o == !output_enable_n_i))
		else $error("output not zero after reset");

	// RQ7 first word reaches the head two cycles after an accepted read
	chk_first_word: assert property (@(posedge mclk_i) disable iff (!rst_n) // RQ7
		($rose(empty_flag_n_o) && read_req && buf_used == 2'h0) |-> rd_go ##2 out_valid_o)
		else $error("first word not readable after empty release");

	// RQ9 almost-empty tracks the count
	chk_almost_empty: assert property (@(posedge mclk_i) disable iff (!rst_n) // RQ9
		(almost_empty_flag_n_o == (cnt_q >= ae_offset_i)) || $changed(ae_offset_i))
		else $error("almost empty flag disagrees with count");

	// RQ10 almost-full tracks the count
	chk_almost_full: assert property (@(posedge mclk_i) disable iff (!rst_n) // RQ10
		(!almost_full_flag_n_o == (cnt_q >= DEPTH_C - af_offset_i + ONE_C))
		|| $changed(af_offset_i))
		else $error("almost full flag disagrees with count");

	// RQ14 no store when full
	chk_full_blocks: assert property (@(posedge mclk_i) disable iff (!rst_n) // RQ14
		(!full_flag_n_o && !read_req) |=> (cnt_q == DEPTH_C && $stable(wr_ptr_q)))
		else $error("write accepted while full");

	// RQ15 no removal when empty
	chk_empty_blocks: assert property (@(posedge mclk_i) disable iff (!rst_n) // RQ15
		(!empty_flag_n_o && !write_req) |=> $stable(rd_ptr_q) ##1 $stable(rd_ptr_q))
		else $error("read accepted while empty");

endmodule : sync_fifo_flags

/* File: fifo_cfg_pkg.sv */
// fifo_cfg_pkg: shared constants for the 9-bit synchronous fifo and its flag logic
// assumes a single 10 MHz system clock; all link edges are enables on that clock
package fifo_cfg_pkg;

	// data path and default depth (one of 64, 256, 512, 1024, 2048, 4096, 8192)
	localparam int DATA_W        = 9;
	localparam int DEPTH_DEFAULT = 64;

	// system clock period
	localparam int CLK_PERIOD_NS = 100;

	// least clock skews for the flags, in ns, and as whole cycles (rounded up, at least one)
	localparam int FLAG_CLOCK_SKEW_FIRST_NS  = 5;
	localparam int FLAG_CLOCK_SKEW_SECOND_NS = 10;
	localparam int FLAG_CLOCK_SKEW_FIRST_CYC =
		(FLAG_CLOCK_SKEW_FIRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLAG_CLOCK_SKEW_SECOND_CYC =
		(FLAG_CLOCK_SKEW_SECOND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// output skid buffer holds two words
	localparam logic [1:0] BUF_ENTRIES = 2'h2;

	// reset values
	localparam logic FLAG_IDLE_N   = 1'b1;
	localparam logic FLAG_ACTIVE_N = 1'b0;

	// role of the dual-purpose enable/load pin, caught during reset
	typedef enum logic [0:0]
	{
		MODE_LOAD      = 1'b0,
		MODE_SECOND_WE = 1'b1
	} pin_mode_t;

endpackage : fifo_cfg_pkg

/* File: fifo_store.sv */
// fifo_store: simple dual-port word memory for the fifo
// assumes caller never reads and writes one address in the same cycle with meaning
`timescale 1ns/10ps
module fifo_store #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 64,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             mclk_i,
	input  wire logic             wr_en_i,
	input  wire logic [AW-1:0]    wr_addr_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	input  wire logic             rd_en_i,
	input  wire logic [AW-1:0]    rd_addr_i,
	output logic      [WIDTH-1:0] rd_data_o
);

	logic [WIDTH-1:0] mem_q [DEPTH];

	// storage has no reset so it maps onto ram
	always_ff @(posedge mclk_i)
	begin
		if (wr_en_i)
			mem_q[wr_addr_i] <= wr_data_i;
	end

	// read data comes out of a register, one cycle after the request
	always_ff @(posedge mclk_i)
	begin
		if (rd_en_i)
			rd_data_o <= mem_q[rd_addr_i];
	end

endmodule : fifo_store

/* File: fifo_sink_model.sv */
// fifo_sink_model: consumer on the head-word side of the fifo
// assumes the bench raises stall_i to hold words back in the skid buffer
`timescale 1ns/10ps
module fifo_sink_model (
	input  wire logic                            mclk_i,
	input  wire logic                            reset_n_i,
	input  wire logic                            stall_i,
	input  wire logic                            valid_i,
	input  wire logic [fifo_cfg_pkg::DATA_W-1:0] data_i,
	output logic                                 ready_o,
	output logic      [7:0]                      count_o,
	output logic      [fifo_cfg_pkg::DATA_W-1:0] last_o
);
	import fifo_cfg_pkg::*;

	// whole-cycle ready
	// ready only moves with stall, which changes at clock edges, so no runt pulses
	assign ready_o = !stall_i;

	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			count_o <= 8'h00;
			last_o  <= '0;
		end
		else if (valid_i && ready_o)
		begin
			count_o <= count_o + 8'h01;
			last_o  <= data_i;
		end
	end
endmodule : fifo_sink_model

/* File: sync_fifo_flags_tb_top.sv */
// sync_fifo_flags_tb_top: self-checking bench for the 64-word fifo and its flags
// assumes the default depth of 64; all inputs move by nba at the rising edge
`timescale 1ns/10ps
module sync_fifo_flags_tb_top;
	import fifo_cfg_pkg::*;
	typedef struct { logic [6:0] n; logic [6:0] m; int af_at; } row_t;
	row_t        rows[2] = '{'{7'h01, 7'h01, 64}, '{7'h08, 7'h05, 60}};
	logic        mclk_i = 1'b0, reset_n_i = 1'b0, we_n = 1'b1, pin = 1'b1;
	logic        ren_a = 1'b1, ren_b = 1'b1, oe_n = 1'b0, stall = 1'b0, rdy;
	logic [8:0]  din = '0, dout, last;
	logic [6:0]  ae_off = 7'h01, af_off = 7'h01;
	logic [7:0]  got;
	logic        oe, vld, ff_n, ef_n, ae_n, af_n, ld, mode;
	int          bad_count = 0, checks_done = 0, cycles = 0, taken;

	sync_fifo_flags u_sync_fifo_flags (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.write_enable_n_i(we_n), .second_enable_or_load_i(pin), .data_i(din),
		.read_enable_a_n_i(ren_a), .read_enable_b_n_i(ren_b), .output_enable_n_i(oe_n),
		.out_ready_i(rdy), .ae_offset_i(ae_off), .af_offset_i(af_off), .data_o(dout),
		.data_oe_o(oe), .out_valid_o(vld), .full_flag_n_o(ff_n), .empty_flag_n_o(ef_n),
		.almost_empty_flag_n_o(ae_n), .almost_full_flag_n_o(af_n), .offset_load_o(ld),
		.second_we_mode_o(mode));
	fifo_sink_model u_fifo_sink_model (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.stall_i(stall), .valid_i(vld), .data_i(dout), .ready_o(rdy), .count_o(got),
		.last_o(last));

	// clock and hang guard; the ceiling is nearly three times the expected run
	initial forever #50 mclk_i = ~mclk_i;
	always @(posedge mclk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			bad_count++;
			give_verdict();
		end
	end

	task automatic chk_bit(input string name, input logic exp, input logic seen);
		checks_done++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %b seen %b", name, exp, seen);
		end
	endtask : chk_bit

	task automatic chk_word(input string name, input logic [8:0] exp, input logic [8:0] seen);
		checks_done++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk_word

	// flag levels expected for k words held in memory
	task automatic chk_flags(input int k, input row_t r);
		chk_bit("empty_n", k != 0, ef_n);
		chk_bit("full_n", k < 64, ff_n);
		chk_bit("almost_empty_n", !(k < int'(r.n)), ae_n);
		chk_bit("almost_full_n", k < r.af_at, af_n);
	endtask : chk_flags

	function automatic logic [8:0] pattern_word(input int k, input int r);
		return 9'(k * 5 + r * 3 + 1);
	endfunction : pattern_word

	task automatic wr(input logic [8:0] d);
		@(posedge mclk_i) we_n <= 1'b0;
		din <= d;
		@(posedge mclk_i) we_n <= 1'b1;
		@(negedge mclk_i);
	endtask : wr

	// one read request, then time for the word to reach the sink
	task automatic rd();
		@(posedge mclk_i) ren_a <= 1'b0;
		ren_b <= 1'b0;
		@(posedge mclk_i) ren_a <= 1'b1;
		ren_b <= 1'b1;
		repeat (4) @(posedge mclk_i);
		@(negedge mclk_i);
	endtask : rd

	// clocks keep running while reset is held
	task automatic do_reset(input logic p);
		@(posedge mclk_i) reset_n_i <= 1'b0;
		pin <= p;
		repeat (8) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		@(negedge mclk_i);
	endtask : do_reset

	task automatic give_verdict();
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	initial
	begin
		do_reset(1'b1);
		chk_flags(0, rows[0]);
		chk_bit("second_we_mode", 1'b1, mode);
		chk_word("data_o", 9'h000, dout);
		chk_bit("data_oe", 1'b1, oe);
		// second-enable strap: a low pin blocks the write and is never a load
		@(posedge mclk_i) we_n <= 1'b0;
		pin <= 1'b0;
		@(negedge mclk_i);
		chk_bit("offset_load", 1'b0, ld);
		@(posedge mclk_i) we_n <= 1'b1;
		pin <= 1'b1;
		@(negedge mclk_i);
		chk_bit("empty_n", 1'b0, ef_n);
		taken = 0;
		foreach (rows[r])
		begin
			@(posedge mclk_i) ae_off <= rows[r].n;
			af_off <= 7'(rows[r].m);
			for (int k = 1; k <= 64; k++)
			begin
				wr(pattern_word(k - 1, r));
				chk_flags(k, rows[r]);
			end
			wr(9'h1ff);
			chk_flags(64, rows[r]);
			// stalled sink: two words fill the skid buffer, the third read is refused
			@(posedge mclk_i) stall <= 1'b1;
			repeat (3) rd();
			chk_flags(62, rows[r]);
			chk_word("sink_count", 9'(taken), {1'b0, got});
			@(posedge mclk_i) stall <= 1'b0;
			repeat (3) @(posedge mclk_i);
			@(negedge mclk_i);
			taken += 2;
			chk_word("sink_count", 9'(taken), {1'b0, got});
			chk_word("sink_word", pattern_word(1, r), last);
			for (int i = 2; i < 64; i++)
			begin
				rd();
				taken++;
				chk_flags(63 - i, rows[r]);
				chk_word("sink_word", pattern_word(i, r), last);
			end
			rd();
			chk_word("sink_count", 9'(taken), {1'b0, got});
		end
		// one enable alone must not read; first word follows empty release
		wr(9'h15a);
		chk_bit("empty_n", 1'b1, ef_n);
		@(posedge mclk_i) ren_a <= 1'b0;
		@(posedge mclk_i) ren_a <= 1'b1;
		repeat (4) @(posedge mclk_i);
		@(negedge mclk_i);
		chk_word("sink_count", 9'(taken), {1'b0, got});
		rd();
		chk_word("sink_word", 9'h15a, last);
		// read raised on the edge that releases empty; head word two edges later
		@(posedge mclk_i) we_n <= 1'b0;
		din <= 9'h0c3;
		@(posedge mclk_i) we_n <= 1'b1;
		ren_a <= 1'b0;
		ren_b <= 1'b0;
		@(posedge mclk_i) ren_a <= 1'b1;
		ren_b <= 1'b1;
		@(negedge mclk_i);
		chk_bit("out_valid", 1'b0, vld);
		chk_bit("empty_n", 1'b0, ef_n);
		@(negedge mclk_i);
		chk_bit("out_valid", 1'b1, vld);
		chk_word("data_o", 9'h0c3, dout);
		@(posedge mclk_i) oe_n <= 1'b1;
		@(negedge mclk_i);
		chk_bit("data_oe", 1'b0, oe);
		// second reset mid-run with a word stored, strapped for offset load
		wr(9'h0aa);
		do_reset(1'b0);
		chk_bit("empty_n", 1'b0, ef_n);
		chk_bit("second_we_mode", 1'b0, mode);
		chk_word("data_o", 9'h000, dout);
		@(posedge mclk_i) we_n <= 1'b0;
		@(negedge mclk_i);
		chk_bit("offset_load", 1'b1, ld);
		@(posedge mclk_i) we_n <= 1'b1;
		@(negedge mclk_i);
		chk_bit("empty_n", 1'b0, ef_n);
		// let the load-cycle assertion finish before the run ends
		repeat (2) @(posedge mclk_i);
		give_verdict();
	end
endmodule : sync_fifo_flags_tb_top
